// File: rtl/fpv_ctrl.sv
// Flash protection, mode decode and RAM overlap redirection.
// Assumes CPU register port on core_clk; pins arrive asynchronously.
// What the document requires of this block and its software
// RULE_01 - Software prewrites every byte to zero before erase, RAM too.
// RULE_02 - Software clears write bit after the programming time.
// RULE_03 - All four control bits clear selects prewrite-verify mode.
// RULE_04 - Prewrite-verify applies verify level; reads return stored data.
// RULE_05 - Software waits 4 us after selecting prewrite-verify.
// RULE_06 - Software protection stops write or wipe entering program/erase.
// RULE_07 - Only selected blocks program or erase; zero selects protect all.
// RULE_08 - One overlap bit alone blocks program/erase, verify stays enabled.
// RULE_09 - No 12 V holds control registers cleared, all modes off.
// RULE_10 - Reset or standby clears control registers, all modes off.
// RULE_11 - Reset pin held low 20 ms power-up, ten cycles running.
// RULE_12 - Interrupt during program/erase aborts it, settings retained.
// RULE_13 - After abort program/erase stay off until reset.
// RULE_14 - Reads while write or wipe set are flagged invalid.
// RULE_15 - Both overlap bits, 12 V and interrupt enable vector overlap.
// RULE_16 - Software places NMI vector at RAM F806 before setting bits.
// RULE_17 - Software keeps NMI handler outside flash.
// RULE_18 - Interrupt mask flag set masks all sources except NMI.
// RULE_19 - Boot user program supplies vector, spares boot RAM area.
// RULE_20 - User program clears overlap bits if interrupts unused.
// RULE_21 - Overlap bits select one of three RAM windows or none.
// RULE_22 - Hardware protection overrides every software setting.
`timescale 1ns/10ps
`default_nettype none
module fpv_ctrl
  import fpv_pkg::*;
#(
  parameter int NBLK1 = 8,
  parameter int NBLK2 = 8
)(
  // Clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic                   clkEn,
  // Register port
  input  wire logic [3:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [7:0]             regRdata,
  // Pins and system events
  input  wire logic                   vppHighPin,
  input  wire logic                   standbyPin,
  input  wire logic                   nmiPin,
  input  wire logic                   irqReq,
  input  wire logic                   intMaskFlag,
  // CPU flash access
  input  wire logic [15:0]            cpuAddr,
  input  wire logic                   cpuFlashRd,
  // Array controls
  output logic                        programEn,
  output logic                        eraseEn,
  output logic                        verifyEn,
  output logic                        preVerifyEn,
  output logic [NBLK1+NBLK2-1:0]      blockEn,
  output logic                        readInvalid,
  output logic                        verifyReady,
  output logic                        ovlActive,
  output logic                        ramSel,
  output logic [15:0]                 mappedAddr,
  output logic                        intTaken,
  output logic [4:0]                  arrayMode
);
  initial
  begin
    if (NBLK1 < 1 || NBLK1 > 8 || NBLK2 < 1 || NBLK2 > 8)
      $error("fpv_ctrl: block counts must be 1..8");
  end

  logic [7:0]  flashCtrl_ff;
  logic [7:0]  blkSel1_ff;
  logic [7:0]  blkSel2_ff;
  logic [7:0]  waitCtrl_ff;
  logic        intProt_ff;
  logic        ovlLatch_ff;
  logic [15:0] settle_ff;
  logic [7:0]  rdata_ff;
  logic        programEn_ff;
  logic        eraseEn_ff;
  logic        verifyEn_ff;
  logic        preVerify_ff;
  logic [NBLK1+NBLK2-1:0] blockEn_ff;
  logic        readInv_ff;
  logic        vReady_ff;
  logic        ramSel_ff;
  logic [15:0] mapped_ff;
  logic        intTaken_ff;
  fpv_mode_t   mode_ff;

  // Pins cross into core_clk
  logic [2:0] pinSync;
  fpv_sync2 #(.W(3)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .clkEn    (clkEn),
    .asyncIn  ({nmiPin, standbyPin, vppHighPin}),
    .syncOut  (pinSync)
  );
  wire vppOk   = pinSync[0];
  wire standby = pinSync[1];
  wire nmiLvl  = pinSync[2];

  // Interrupt qualification
  wire anyInt  = nmiLvl | (irqReq & ~intMaskFlag); // [RULE_18]

  // Hardware protection dominates
  wire hwClear = standby | ~vppOk;                  // [RULE_09] [RULE_10]
  wire hwBlock = hwClear | intProt_ff;              // [RULE_22]

  wire wrBit   = flashCtrl_ff[BIT_WRITE];
  wire wpBit   = flashCtrl_ff[BIT_WIPE];
  wire pvBit   = flashCtrl_ff[BIT_WRCHK];
  wire evBit   = flashCtrl_ff[BIT_WIPECHK];
  wire ovlHi   = waitCtrl_ff[BIT_OVL_HIGH];
  wire ovlLo   = waitCtrl_ff[BIT_OVL_LOW];

  // Emulation protect: exactly one overlap bit
  wire emuProt = ovlHi ^ ovlLo;                     // [RULE_08]
  wire [NBLK1+NBLK2-1:0] blkSelAll =
    {blkSel2_ff[NBLK2-1:0], blkSel1_ff[NBLK1-1:0]};
  wire anyBlk  = |blkSelAll;                        // [RULE_07]
  wire swBlock = emuProt | ~anyBlk;                 // [RULE_06]

  wire busy    = (wrBit | wpBit) & ~hwBlock & ~swBlock;
  wire abortEv = busy & anyInt;                     // [RULE_12]

  wire nxt_program = wrBit & ~hwBlock & ~swBlock & ~abortEv;
  wire nxt_erase   = wpBit & ~wrBit & ~hwBlock & ~swBlock & ~abortEv;
  wire nxt_verify  = (pvBit | evBit) & ~hwClear;    // [RULE_08]
  wire nxt_prever  = ~(wrBit | wpBit | pvBit | evBit) & ~hwClear; // [RULE_03]
  wire [NBLK1+NBLK2-1:0] nxt_blockEn =
    (nxt_program | nxt_erase) ? blkSelAll : '0;    // [RULE_07]

  fpv_mode_t nxt_mode;
  always_comb
  begin
    nxt_mode = MODE_OFF;
    if (nxt_program)
      nxt_mode = MODE_PROGRAM;
    else if (nxt_erase)
      nxt_mode = MODE_ERASE;
    else if (nxt_verify)
      nxt_mode = MODE_VERIFY;
    else if (nxt_prever)
      nxt_mode = MODE_PREVERIFY;
  end

  // Settle counter restarts when prewrite-verify is entered
  wire enterPv = nxt_prever & ~preVerify_ff;
  wire [15:0] nxt_settle = enterPv ? 16'h0000 :
    (settle_ff < 16'(VSET_CYC)) ? settle_ff + 16'h0001 : settle_ff;

  // Overlap window decode
  function automatic logic inWin(input logic [15:0] a,
                                 input logic [1:0]  sel);
    unique case (sel)
      2'b01:   inWin = (a >= ROM_BASE_SB) && (a <= ROM_END_01);
      2'b10:   inWin = (a >= ROM_BASE_SB) && (a <= ROM_END_10);
      2'b11:   inWin = (a <= ROM_END_11);
      default: inWin = 1'b0;
    endcase
  endfunction

  wire [1:0] ovlSel  = {ovlHi, ovlLo};
  wire bothOvl       = ovlHi & ovlLo;
  // Full overlap only once an interrupt arrives under 12 V
  wire ovlLatchSet   = bothOvl & vppOk & anyInt;    // [RULE_15]
  wire nxt_ovlLatch  = bothOvl & (ovlLatch_ff | ovlLatchSet);
  wire ovlOn         = (ovlSel == 2'b01) | (ovlSel == 2'b10) | nxt_ovlLatch;
  wire hit           = ovlOn & inWin(cpuAddr, ovlSel); // [RULE_21]
  wire [15:0] ramOfs = bothOvl ? RAM_BASE_ALL - ROM_BASE_ALL
                               : RAM_BASE_SB - ROM_BASE_SB;
  wire [15:0] nxt_mapped = hit ? cpuAddr + ramOfs : cpuAddr;

  // Register read mux
  wire [7:0] statusVal = {3'h0, ovlLatch_ff, vReady_ff, intProt_ff,
                          standby, vppOk};
  wire [7:0] rdMux =
    (regAddr == ADDR_FLASH_CTRL) ? flashCtrl_ff :
    (regAddr == ADDR_BLKSEL1)    ? blkSel1_ff   :
    (regAddr == ADDR_BLKSEL2)    ? blkSel2_ff   :
    (regAddr == ADDR_WAIT_CTRL)  ? waitCtrl_ff  :
    (regAddr == ADDR_STATUS)     ? statusVal    : 8'h00;

  wire wrCtrl = regWr & (regAddr == ADDR_FLASH_CTRL);
  wire wrB1   = regWr & (regAddr == ADDR_BLKSEL1);
  wire wrB2   = regWr & (regAddr == ADDR_BLKSEL2);
  wire wrWait = regWr & (regAddr == ADDR_WAIT_CTRL);

  // Control registers; hardware clear wins over writes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      flashCtrl_ff <= RST_FLASH_CTRL;               // [RULE_10]
      blkSel1_ff   <= RST_BLKSEL;
      blkSel2_ff   <= RST_BLKSEL;
    end
    else if (clkEn)
    begin
      if (hwClear)
      begin
        flashCtrl_ff <= RST_FLASH_CTRL;             // [RULE_09] [RULE_10]
        blkSel1_ff   <= RST_BLKSEL;
        blkSel2_ff   <= RST_BLKSEL;
      end
      else
      begin
        if (wrCtrl)
          flashCtrl_ff <= {4'h0, regWdata[3:0]};
        if (wrB1)
          blkSel1_ff <= regWdata;
        if (wrB2)
          blkSel2_ff <= regWdata;
      end
    end
  end

  // Wait control is only cleared by reset, not by standby pin
  always_ff @(posedge core_clk)
  begin
    if (srst)
      waitCtrl_ff <= RST_WAIT_CTRL;
    else if (clkEn && wrWait)
      waitCtrl_ff <= regWdata;
  end

  // Interrupt protection is sticky until reset
  always_ff @(posedge core_clk)
  begin
    if (srst)
      intProt_ff <= 1'b0;
    else if (clkEn && abortEv)
      intProt_ff <= 1'b1;                           // [RULE_13]
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ovlLatch_ff <= 1'b0;
      settle_ff   <= 16'h0000;
    end
    else if (clkEn)
    begin
      ovlLatch_ff <= nxt_ovlLatch;
      settle_ff   <= nxt_settle;
    end
  end

  // Array control outputs, all registered
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      programEn_ff <= 1'b0;
      eraseEn_ff   <= 1'b0;
      verifyEn_ff  <= 1'b0;
      preVerify_ff <= 1'b0;
      blockEn_ff   <= '0;
      mode_ff      <= MODE_OFF;
    end
    else if (clkEn)
    begin
      programEn_ff <= nxt_program;                  // [RULE_06]
      eraseEn_ff   <= nxt_erase;
      verifyEn_ff  <= nxt_verify;
      preVerify_ff <= nxt_prever;                   // [RULE_04]
      blockEn_ff   <= nxt_blockEn;
      mode_ff      <= nxt_mode;
    end
  end

  // Access side outputs
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rdata_ff    <= 8'h00;
      readInv_ff  <= 1'b0;
      vReady_ff   <= 1'b0;
      ramSel_ff   <= 1'b0;
      mapped_ff   <= 16'h0000;
      intTaken_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      rdata_ff    <= regRd ? rdMux : 8'h00;
      readInv_ff  <= cpuFlashRd & ~hit & (wrBit | wpBit); // [RULE_14]
      vReady_ff   <= nxt_prever & ~enterPv &
                     (nxt_settle >= 16'(VSET_CYC));
      ramSel_ff   <= hit;                           // [RULE_15]
      mapped_ff   <= nxt_mapped;                    // [RULE_21]
      intTaken_ff <= anyInt;                        // [RULE_18]
    end
  end

  assign regRdata    = rdata_ff;
  assign programEn   = programEn_ff;
  assign eraseEn     = eraseEn_ff;
  assign verifyEn    = verifyEn_ff;
  assign preVerifyEn = preVerify_ff;
  assign blockEn     = blockEn_ff;
  assign readInvalid = readInv_ff;
  assign verifyReady = vReady_ff;
  assign ovlActive   = ovlLatch_ff;
  assign ramSel      = ramSel_ff;
  assign mappedAddr  = mapped_ff;
  assign intTaken    = intTaken_ff;
  assign arrayMode   = mode_ff;
endmodule
`default_nettype wire

// File: rtl/fpv_pkg.sv
// Constants for the flash protect and prewrite-verify controller.
// Assumes one 100 MHz core clock and a plain register port.
package fpv_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_FLASH_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BLKSEL1    = 4'h1;
  localparam logic [3:0] ADDR_BLKSEL2    = 4'h2;
  localparam logic [3:0] ADDR_WAIT_CTRL  = 4'h3;
  localparam logic [3:0] ADDR_STATUS     = 4'h4;
  // Flash control field positions
  localparam int BIT_WRITE      = 0;
  localparam int BIT_WIPE       = 1;
  localparam int BIT_WRCHK      = 2;
  localparam int BIT_WIPECHK    = 3;
  // Wait control field positions
  localparam int BIT_OVL_LOW    = 6;
  localparam int BIT_OVL_HIGH   = 7;
  // Reset values
  localparam logic [7:0] RST_FLASH_CTRL = 8'h00;
  localparam logic [7:0] RST_BLKSEL     = 8'h00;
  localparam logic [7:0] RST_WAIT_CTRL  = 8'h08;
  // Value prewritten before erase
  localparam logic [7:0] PREWRITE_VAL   = 8'h00;
  // Overlap windows
  localparam logic [15:0] RAM_BASE_ALL  = 16'hF800;
  localparam logic [15:0] RAM_BASE_SB   = 16'hF880;
  localparam logic [15:0] ROM_BASE_ALL  = 16'h0000;
  localparam logic [15:0] ROM_BASE_SB   = 16'h0080;
  localparam logic [15:0] ROM_END_01    = 16'h00FF;
  localparam logic [15:0] ROM_END_10    = 16'h017F;
  localparam logic [15:0] ROM_END_11    = 16'h007F;
  // Verify settling time
  localparam int CLK_MHZ       = 100;
  localparam int VSET_US       = 4;
  localparam int VSET_CYC      = VSET_US * CLK_MHZ;
  // Array operating modes
  typedef enum logic [4:0] {
    MODE_PREVERIFY = 5'b00001,
    MODE_PROGRAM   = 5'b00010,
    MODE_ERASE     = 5'b00100,
    MODE_VERIFY    = 5'b01000,
    MODE_OFF       = 5'b10000
  } fpv_mode_t;
endpackage

// File: rtl/fpv_sync2.sv
// Two-flop synchroniser for pin levels.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module fpv_sync2
  import fpv_pkg::*;
#(
  parameter int W = 1
)(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         clkEn,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  initial
  begin
    if (W < 1) $error("fpv_sync2: W must be at least 1");
  end
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else if (clkEn)
    begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end
  assign syncOut = sync_ff;
endmodule
`default_nettype wire

// File: test/fpv_checker.sv
// Port-level checker for fpv_ctrl, bound into every instance.
// Assumes clkEn stays high; shadows the overlap bits from the bus.
`timescale 1ns/10ps
`default_nettype none
module fpv_checker
  import fpv_pkg::*;
#(
  parameter int NBLK1 = 8,
  parameter int NBLK2 = 8
)(
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   srst,
  // Register writes
  input wire logic [3:0]             regAddr,
  input wire logic [7:0]             regWdata,
  input wire logic                   regWr,
  // Pins and CPU side
  input wire logic                   vppHighPin,
  input wire logic                   standbyPin,
  input wire logic                   irqReq,
  input wire logic                   intMaskFlag,
  input wire logic [15:0]            cpuAddr,
  input wire logic                   cpuFlashRd,
  // Array side
  input wire logic                   programEn,
  input wire logic                   eraseEn,
  input wire logic                   verifyEn,
  input wire logic                   preVerifyEn,
  input wire logic [NBLK1+NBLK2-1:0] blockEn,
  input wire logic                   readInvalid,
  input wire logic                   verifyReady,
  input wire logic                   ovlActive,
  input wire logic                   ramSel,
  input wire logic [15:0]            mappedAddr,
  input wire logic [4:0]             arrayMode
);
  logic [1:0] ovlSh_ff;
  logic       intProt_ff;
  wire        wrWait = regWr && (regAddr == ADDR_WAIT_CTRL);
  wire  [1:0] nxt_ovlSh = wrWait ? regWdata[7:6] : ovlSh_ff;
  wire        ovlOne = ^ovlSh_ff;
  wire        busy = programEn || eraseEn;
  wire        abortNow = busy && irqReq && !intMaskFlag;
  wire        allOff = !busy && !verifyEn && !preVerifyEn;
  // Sticky copy, only a reset may clear it
  wire        nxt_intProt = intProt_ff || abortNow;
  always_ff @(posedge core_clk)
  begin
    ovlSh_ff   <= srst ? RST_WAIT_CTRL[7:6] : nxt_ovlSh;
    intProt_ff <= srst ? 1'b0 : nxt_intProt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_reset_values: assert property ($fell(srst) |-> allOff &&
    arrayMode == 5'h10 && blockEn == '0) else $error("reset values");
  chk_vpp_off: assert property ((!vppHighPin)[*5] |-> allOff)
    else $error("modes on without vpp");
  chk_standby_off: assert property (standbyPin[*5] |-> allOff)
    else $error("modes on in standby");
  chk_mode_decode: assert property ($onehot(arrayMode) &&
    programEn == arrayMode[1] && eraseEn == arrayMode[2] &&
    preVerifyEn == arrayMode[0]) else $error("mode decode");
  chk_block_gate: assert property (!busy |-> blockEn == '0)
    else $error("blocks enabled while idle");
  chk_ovl_protect: assert property ($past(ovlOne) && ovlOne |-> !busy)
    else $error("program under single overlap");
  chk_int_abort: assert property (abortNow |=> !busy)
    else $error("no abort on interrupt");
  chk_int_sticky: assert property (intProt_ff |-> !busy)
    else $error("program after abort");
  chk_read_flag: assert property (readInvalid |-> $past(cpuFlashRd))
    else $error("invalid flag without read");
  chk_vector_map: assert property (ramSel && $past(cpuAddr) <= 16'h007F
    |-> mappedAddr == (RAM_BASE_ALL | $past(cpuAddr)))
    else $error("vector redirect address");
  cov_abort: cover property (abortNow);
  cov_overlap: cover property ($rose(ovlActive));
  cov_ready: cover property ($rose(verifyReady));
endmodule
bind fpv_ctrl fpv_checker #(.NBLK1(NBLK1), .NBLK2(NBLK2)) fpv_checker_i (
  .core_clk(core_clk), .srst(srst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .vppHighPin(vppHighPin),
  .standbyPin(standbyPin), .irqReq(irqReq), .intMaskFlag(intMaskFlag),
  .cpuAddr(cpuAddr), .cpuFlashRd(cpuFlashRd), .programEn(programEn),
  .eraseEn(eraseEn), .verifyEn(verifyEn), .preVerifyEn(preVerifyEn),
  .blockEn(blockEn), .readInvalid(readInvalid),
  .verifyReady(verifyReady), .ovlActive(ovlActive), .ramSel(ramSel),
  .mappedAddr(mappedAddr), .arrayMode(arrayMode));
`default_nettype wire

// File: test/fpv_cpu_model.sv
// CPU model: flash software driving the register port.
// Assumes read data stand one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module fpv_cpu_model
  import fpv_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic      [3:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdata
);
  initial
  begin
    regAddr  = 4'hF;
    regWdata = 8'hA5;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end
  // Idle lines show junk so nothing relies on stale values
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr    <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd   <= 1'b0;
    regAddr <= ~a;
    // Data stand only until the next edge; take them 1 ns after this one
    #1;
    d = regRdata;
  endtask
  // Array data PREWRITE_VAL travels outside this port
  task automatic prewrite();
    wr(ADDR_FLASH_CTRL, 8'h01);
    wr(ADDR_FLASH_CTRL, 8'h00);
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for fpv_ctrl with a CPU model on the port.
// Assumes a 100 MHz core_clk; clkEn stays high throughout.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fpv_pkg::*;
  logic core_clk = 0, srst = 1, vppHighPin = 0, standbyPin = 0;
  logic nmiPin = 0, irqReq = 0, intMaskFlag = 0, cpuFlashRd = 0;
  logic [15:0] cpuAddr = 16'h0000, blockEn, mappedAddr;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, d;
  logic regWr, regRd, programEn, eraseEn, verifyEn, preVerifyEn;
  logic readInvalid, verifyReady, ovlActive, ramSel, intTaken;
  logic [4:0] arrayMode;
  int miscompares = 0, checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  fpv_cpu_model fpv_cpu_model_i (.core_clk(core_clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  fpv_ctrl fpv_ctrl_i (.core_clk(core_clk), .srst(srst), .clkEn(1'b1),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .vppHighPin(vppHighPin),
    .standbyPin(standbyPin), .nmiPin(nmiPin), .irqReq(irqReq),
    .intMaskFlag(intMaskFlag), .cpuAddr(cpuAddr),
    .cpuFlashRd(cpuFlashRd), .programEn(programEn), .eraseEn(eraseEn),
    .verifyEn(verifyEn), .preVerifyEn(preVerifyEn), .blockEn(blockEn),
    .readInvalid(readInvalid), .verifyReady(verifyReady),
    .ovlActive(ovlActive), .ramSel(ramSel), .mappedAddr(mappedAddr),
    .intTaken(intTaken), .arrayMode(arrayMode));
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic cmpB(input string n, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic cmpW(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ctrl(input logic [7:0] v);
    fpv_cpu_model_i.wr(ADDR_FLASH_CTRL, v);
    settle(2);
  endtask
  task automatic t_reset();
    fpv_cpu_model_i.rd(ADDR_WAIT_CTRL, d);
    cmpW("waitctrl", {8'h00, RST_WAIT_CTRL}, {8'h00, d});
    fpv_cpu_model_i.rd(4'h9, d);
    cmpW("unmapped", 16'h0000, {8'h00, d});
    cmpB("preverify", 1'b0, preVerifyEn);
    cmpW("mode", 16'h0010, {11'h000, arrayMode});
    @(posedge core_clk) vppHighPin <= 1'b1;
    settle(4);
  endtask
  task automatic t_prog();
    fpv_cpu_model_i.wr(ADDR_BLKSEL1, 8'h01);
    fpv_cpu_model_i.wr(ADDR_BLKSEL2, 8'h80);
    ctrl(8'h01);
    cmpW("blocks", 16'h8001, blockEn);
    @(posedge core_clk) cpuFlashRd <= 1'b1;
    @(posedge core_clk) cpuAddr <= 16'h1000;
    settle(2);
    cmpB("rdinvalid", 1'b1, readInvalid);
    @(posedge core_clk) cpuFlashRd <= 1'b0;
    ctrl(8'h03);
    cmpW("bothbits", 16'h0002, {11'h000, arrayMode});
    ctrl(8'h02);
    cmpB("erase", 1'b1, eraseEn);
    ctrl(8'h04);
    cmpB("verify", 1'b1, verifyEn);
    fpv_cpu_model_i.wr(ADDR_BLKSEL1, 8'h00);
    fpv_cpu_model_i.wr(ADDR_BLKSEL2, 8'h00);
    ctrl(8'h01);
    cmpW("noblocks", 16'h0000, blockEn);
    fpv_cpu_model_i.prewrite();
    settle(2);
    cmpB("preverify", 1'b1, preVerifyEn);
    cmpB("notready", 1'b0, verifyReady);
    settle(VSET_CYC + 3);
    cmpB("ready", 1'b1, verifyReady);
  endtask
  task automatic t_ovl();
    fpv_cpu_model_i.wr(ADDR_BLKSEL1, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      fpv_cpu_model_i.wr(ADDR_WAIT_CTRL, i ? 8'h80 : 8'h40);
      ctrl(8'h01);
      cmpB("ovlprog", 1'b0, programEn);
      ctrl(8'h04);
      cmpB("ovlverify", 1'b1, verifyEn);
    end
    ctrl(8'h00);
    fpv_cpu_model_i.wr(ADDR_WAIT_CTRL, 8'h40);
    @(posedge core_clk) cpuAddr <= 16'h00FF;
    settle(2);
    cmpW("map01", 16'hF8FF, ramSel ? mappedAddr : 16'h0000);
    fpv_cpu_model_i.wr(ADDR_WAIT_CTRL, 8'h80);
    @(posedge core_clk) cpuAddr <= 16'h017F;
    settle(2);
    cmpW("map10", 16'hF97F, ramSel ? mappedAddr : 16'h0000);
    fpv_cpu_model_i.wr(ADDR_WAIT_CTRL, 8'hC0);
    @(posedge core_clk) cpuAddr <= 16'h0006;
    settle(2);
    cmpB("ovlwait", 1'b0, ramSel);
    @(posedge core_clk) irqReq <= 1'b1;
    settle(3);
    cmpB("ovlfull", 1'b1, ovlActive);
    cmpW("nmivec", 16'hF806, ramSel ? mappedAddr : 16'h0000);
    @(posedge core_clk) irqReq <= 1'b0;
    fpv_cpu_model_i.wr(ADDR_WAIT_CTRL, 8'h00);
    settle(2);
    cmpB("ovloff", 1'b0, ovlActive);
  endtask
  task automatic t_hw();
    for (int k = 0; k < 2; k++)
    begin
      fpv_cpu_model_i.wr(ADDR_BLKSEL1, 8'h01);
      ctrl(8'h01);
      @(posedge core_clk)
      begin
        vppHighPin <= k[0];
        standbyPin <= k[0];
      end
      settle(6);
      cmpB("hwprog", 1'b0, programEn);
      fpv_cpu_model_i.rd(ADDR_FLASH_CTRL, d);
      cmpW("hwctrl", 16'h0000, {8'h00, d});
      ctrl(8'h01);
      cmpB("hwwins", 1'b0, programEn);
      @(posedge core_clk)
      begin
        vppHighPin <= 1'b1;
        standbyPin <= 1'b0;
      end
      settle(4);
      fpv_cpu_model_i.rd(ADDR_BLKSEL1, d);
      cmpW("hwblk", 16'h0000, {8'h00, d});
    end
  endtask
  task automatic t_int();
    fpv_cpu_model_i.wr(ADDR_BLKSEL1, 8'h01);
    ctrl(8'h01);
    @(posedge core_clk) intMaskFlag <= 1'b1;
    @(posedge core_clk) irqReq <= 1'b1;
    settle(4);
    cmpB("masked", 1'b1, programEn);
    cmpB("nointtaken", 1'b0, intTaken);
    @(posedge core_clk) nmiPin <= 1'b1;
    settle(4);
    cmpB("nmiabort", 1'b0, programEn);
    cmpB("nmitaken", 1'b1, intTaken);
    @(posedge core_clk) nmiPin <= 1'b0;
    fpv_cpu_model_i.rd(ADDR_FLASH_CTRL, d);
    cmpW("kept", 16'h0001, {8'h00, d});
    ctrl(8'h00);
    ctrl(8'h01);
    cmpB("sticky", 1'b0, programEn);
    ctrl(8'h04);
    cmpB("verifyok", 1'b1, verifyEn);
    @(posedge core_clk) srst <= 1'b1;
    settle(10);
    @(posedge core_clk) srst <= 1'b0;
    settle(4);
    fpv_cpu_model_i.wr(ADDR_BLKSEL1, 8'h01);
    ctrl(8'h01);
    cmpB("released", 1'b1, programEn);
    @(posedge core_clk) intMaskFlag <= 1'b0;
    settle(2);
    cmpB("irqabort", 1'b0, programEn);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_prog();
    t_ovl();
    t_hw();
    t_int();
    summarize();
  end
endmodule
`default_nettype wire
